/* File: core/swap_dir_exec.sv */
// Executor for the nibble-swap and direction-load instructions
`timescale 1ns/1ps

module swap_dir_exec
   import swap_dir_pkg::*;
   #(parameter int RAM_DEPTH = 128)
   (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Instruction from decode
   input wire logic instr_valid,
   input wire logic [INSTR_W-1:0] instr,
   input wire logic bank_sel,
   // Working register load from the rest of the core
   input wire logic w_load_en,
   input wire logic [DATA_W-1:0] w_load_data,
   // Addressed register access
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wr_data,
   output logic reg_wr_done,
   output logic reg_rd_valid,
   output logic [DATA_W-1:0] reg_rd_data,
   // Core state
   output logic [DATA_W-1:0] w_reg,
   output logic [DATA_W-1:0] dir_a,
   output logic [DATA_W-1:0] dir_b,
   output logic [DATA_W-1:0] dir_c,
   output logic retire
   );

   // ---------------------------------------------------------------
   // Decode stage
   // ---------------------------------------------------------------
   logic d_swap;
   logic d_dirload;
   logic [ADDR_W-1:0] d_addr;
   logic s1_valid;
   logic s1_swap;
   logic s1_dest;
   logic [ADDR_W-1:0] s1_addr;
   logic [1:0] s1_dir;

   always_comb
   begin
      d_swap = instr_valid && op_is_swap(instr);
      d_dirload = instr_valid && op_is_dirload(instr);
      d_addr = {bank_sel, instr[FILE_ADDR_W-1:0]};
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s1_valid <= 1'b0;
         s1_swap <= 1'b0;
         s1_dest <= 1'b0;
         s1_addr <= '0;
         s1_dir <= '0;
      end
      else
      begin
         s1_valid <= d_swap || d_dirload;
         s1_swap <= d_swap;
         s1_dest <= instr[DEST_BIT];
         s1_addr <= d_addr;
         s1_dir <= 2'(instr[2:0] - DIRLOAD_FIRST);
      end
   end

   // ---------------------------------------------------------------
   // File memory and forwarding
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] dir_q [0:DIR_COUNT-1];
   logic [DATA_W-1:0] ram_q;
   logic [DATA_W-1:0] src;
   logic [DATA_W-1:0] swapped;
   logic ex_swap_w;
   logic ex_back;
   logic ex_dirload;
   logic ex_busy;
   logic ram_we;
   logic [FILE_ADDR_W-1:0] ram_waddr;
   logic [DATA_W-1:0] ram_wdata;
   logic fwd_valid;
   logic [FILE_ADDR_W-1:0] fwd_addr;
   logic [DATA_W-1:0] fwd_data;
   logic ext_wr_ok;
   logic ext_rd_ok;

   // The memory read misses a write landing on the same edge, so the
   // last write is held and forwarded to a back-to-back swap source read; addressed reads are not forwarded
   always_comb
   begin
      if (is_dir_addr(s1_addr))
         src = dir_q[dir_index(s1_addr)];
      else if (fwd_valid && (fwd_addr == s1_addr[FILE_ADDR_W-1:0]))
         src = fwd_data;
      else
         src = ram_q;
      swapped = swap_nibbles(src);
      ex_swap_w = s1_valid && s1_swap && !s1_dest;
      ex_back = s1_valid && s1_swap && s1_dest;
      ex_dirload = s1_valid && !s1_swap;
      ex_busy = ex_back || ex_dirload;
      ext_wr_ok = reg_wr_en && !ex_busy;
      ext_rd_ok = reg_rd_en && !d_swap;
      ram_we = (ex_back && !is_dir_addr(s1_addr))
         || (ext_wr_ok && !is_dir_addr(reg_addr));
      ram_waddr = ex_back ? s1_addr[FILE_ADDR_W-1:0]
         : reg_addr[FILE_ADDR_W-1:0];
      ram_wdata = ex_back ? swapped : reg_wr_data;
   end

   file_ram #(
      .WIDTH(DATA_W),
      .DEPTH(RAM_DEPTH),
      .AW(FILE_ADDR_W)
   ) u_ram (
      .clock(clock),
      .wr_en(ram_we),
      .wr_addr(ram_waddr),
      .wr_data(ram_wdata),
      .rd_addr(d_swap ? d_addr[FILE_ADDR_W-1:0]
         : reg_addr[FILE_ADDR_W-1:0]),
      .rd_data(ram_q)
   );

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         fwd_valid <= 1'b0;
         fwd_addr <= '0;
         fwd_data <= '0;
      end
      else
      begin
         fwd_valid <= ram_we;
         fwd_addr <= ram_waddr;
         fwd_data <= ram_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Working and direction registers
   // ---------------------------------------------------------------
   // Execution wins over a plain W load in the same cycle
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         w_reg <= W_RESET;
      else if (ex_swap_w)
         w_reg <= swapped;
      else if (w_load_en)
         w_reg <= w_load_data;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         for (int k = 0; k < DIR_COUNT; k++)
            dir_q[k] <= DIR_RESET;
      end
      else if (ex_dirload)
         dir_q[s1_dir] <= w_reg;
      else if (ex_back && is_dir_addr(s1_addr))
         dir_q[dir_index(s1_addr)] <= swapped;
      else if (ext_wr_ok && is_dir_addr(reg_addr))
         dir_q[dir_index(reg_addr)] <= reg_wr_data;
   end

   assign dir_a = dir_q[0];
   assign dir_b = dir_q[1];
   assign dir_c = dir_q[2];

   // ---------------------------------------------------------------
   // Addressed access answers and retire
   // ---------------------------------------------------------------
   logic rd_pend;
   logic rd_pend_dir;
   logic [DATA_W-1:0] rd_pend_dir_data;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rd_pend <= 1'b0;
         rd_pend_dir <= 1'b0;
         rd_pend_dir_data <= '0;
         reg_rd_valid <= 1'b0;
         reg_rd_data <= '0;
         reg_wr_done <= 1'b0;
      end
      else
      begin
         rd_pend <= ext_rd_ok;
         rd_pend_dir <= is_dir_addr(reg_addr);
         // Only a direction address may index the three-entry array
         rd_pend_dir_data <= is_dir_addr(reg_addr)
            ? dir_q[dir_index(reg_addr)] : '0;
         reg_rd_valid <= rd_pend;
         reg_rd_data <= rd_pend_dir ? rd_pend_dir_data : ram_q;
         reg_wr_done <= ext_wr_ok;
      end
   end

   // Status flags are never driven from here
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         retire <= 1'b0;
      else
         retire <= s1_valid;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence swap_issue;
      instr_valid && op_is_swap(instr);
   endsequence

   sequence dirload_issue;
      instr_valid && op_is_dirload(instr);
   endsequence

   swap_to_w_a: assert property (@(posedge clock) disable iff (sys_rst)
      ex_swap_w |=> w_reg[7:4] == $past(src[3:0])
         && w_reg[3:0] == $past(src[7:4]))
      else $error("W does not hold the swapped source");

   src_kept_a: assert property (@(posedge clock) disable iff (sys_rst)
      ex_swap_w && !(ext_wr_ok && is_dir_addr(reg_addr))
      |-> (!ram_we || ext_wr_ok)
         ##1 $stable(dir_a) && $stable(dir_b) && $stable(dir_c))
      else $error("Source changed when the result went to W");

   swap_back_a: assert property (@(posedge clock) disable iff (sys_rst)
      ex_back && !is_dir_addr(s1_addr)
      |-> ram_we && ram_waddr == s1_addr[FILE_ADDR_W-1:0]
         && ram_wdata == {src[3:0], src[7:4]} ##1 $stable(w_reg)
         || $past(w_load_en))
      else $error("Swap result not written back to its source");

   dirload_copy_a: assert property (@(posedge clock) disable iff (sys_rst)
      ex_dirload |=> dir_q[$past(s1_dir)] == $past(w_reg))
      else $error("Direction register did not take W");

   dirload_seq_a: assert property (@(posedge clock) disable iff (sys_rst)
      dirload_issue ##1 1'b1 |-> ex_dirload)
      else $error("Direction-load did not reach execute");

   dir_write_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr_en && !ex_busy && is_dir_addr(reg_addr)
      |=> reg_wr_done && dir_q[dir_index($past(reg_addr))]
         == $past(reg_wr_data))
      else $error("Addressed write to a direction register lost");

   dir_read_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd_en && !d_swap && is_dir_addr(reg_addr) && !reg_wr_en
         && !ex_busy
      |-> ##2 reg_rd_valid
         && reg_rd_data == $past(dir_q[dir_index(reg_addr)], 2))
      else $error("Addressed read of a direction register wrong");

   one_cycle_a: assert property (@(posedge clock) disable iff (sys_rst)
      (swap_issue or dirload_issue) |-> ##2 retire)
      else $error("Instruction did not retire two edges after issue");

endmodule : swap_dir_exec

/* File: core/swap_dir_pkg.sv */
// Constants and helpers for the nibble-swap and direction-load executor
package swap_dir_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int INSTR_W = 14;
   localparam int FILE_ADDR_W = 7;
   localparam int ADDR_W = 8;
   localparam int DIR_COUNT = 3;

   // ---------------------------------------------------------------
   // Instruction encodings
   // ---------------------------------------------------------------
   localparam logic [5:0] SWAP_OPCODE = 6'h0E;
   localparam logic [10:0] DIRLOAD_OPCODE = 11'h00C;
   localparam int DEST_BIT = 7;
   localparam logic [2:0] DIRLOAD_FIRST = 3'h5;

   // ---------------------------------------------------------------
   // Direction register map and reset values
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] DIR_ADDR_FIRST = 8'h85;
   localparam logic [ADDR_W-1:0] DIR_ADDR_LAST = 8'h87;
   localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;
   localparam logic [DATA_W-1:0] W_RESET = 8'h00;

   function automatic logic op_is_swap(input logic [INSTR_W-1:0] i);
      op_is_swap = (i[13:8] == SWAP_OPCODE);
   endfunction : op_is_swap

   // Operands outside 5..7 do not name a direction register
   function automatic logic op_is_dirload(input logic [INSTR_W-1:0] i);
      op_is_dirload = (i[13:3] == DIRLOAD_OPCODE)
         && (i[2:0] >= DIRLOAD_FIRST);
   endfunction : op_is_dirload

   function automatic logic [DATA_W-1:0] swap_nibbles(
      input logic [DATA_W-1:0] v);
      swap_nibbles = {v[3:0], v[7:4]};
   endfunction : swap_nibbles

   function automatic logic is_dir_addr(input logic [ADDR_W-1:0] a);
      is_dir_addr = (a >= DIR_ADDR_FIRST) && (a <= DIR_ADDR_LAST);
   endfunction : is_dir_addr

   function automatic logic [1:0] dir_index(input logic [ADDR_W-1:0] a);
      dir_index = 2'(a - DIR_ADDR_FIRST);
   endfunction : dir_index

endpackage : swap_dir_pkg

/* File: core/file_ram.sv */
// File register memory with registered read data
`timescale 1ns/1ps

module file_ram
   #(parameter int WIDTH = 8,
     parameter int DEPTH = 128,
     parameter int AW = 7)
   (
   // Clock
   input wire logic clock,
   // Write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // Read port
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
   );

   logic [WIDTH-1:0] mem [0:DEPTH-1];

   // Read before write: a same-edge write is not seen by the read
   always_ff @(posedge clock)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clock)
   begin
      rd_data <= mem[rd_addr];
   end

endmodule : file_ram

/* File: tb/tb_top.sv */
// Self-checking bench for the nibble-swap and direction-load executor
`timescale 1ns/1ps

module tb_top
   import swap_dir_pkg::*;
   ();

   logic clock, sys_rst, instr_valid, bank_sel, w_load_en;
   logic reg_wr_en, reg_rd_en, reg_wr_done, reg_rd_valid, retire;
   logic [INSTR_W-1:0] instr;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] w_load_data, reg_wr_data, reg_rd_data, w_reg;
   logic [DATA_W-1:0] dir_a, dir_b, dir_c, got, wm;
   logic [DATA_W-1:0] mem [0:127];
   logic [DATA_W-1:0] dirm [0:2];
   logic [31:0] seed;
   logic [ADDR_W-1:0] a;
   int num_errors, checked;

   swap_dir_exec DUT (.clock(clock), .sys_rst(sys_rst),
      .instr_valid(instr_valid), .instr(instr), .bank_sel(bank_sel),
      .w_load_en(w_load_en), .w_load_data(w_load_data),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr_done(reg_wr_done),
      .reg_rd_valid(reg_rd_valid), .reg_rd_data(reg_rd_data),
      .w_reg(w_reg), .dir_a(dir_a), .dir_b(dir_b), .dir_c(dir_c),
      .retire(retire));

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic give_verdict;
      $display("errors %0d of %0d checks", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   task automatic cmp(input logic [7:0] g, e, input string m);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : cmp

   task automatic cmp_bit(input logic g, e, input string m);
      cmp({7'h00, g}, {7'h00, e}, m);
   endtask : cmp_bit

   task automatic tick;
      @(posedge clock);
      #1;
   endtask : tick

   task automatic ran_out;
      num_errors++;
      $display("BAD %0t wait ran out", $time);
      give_verdict;
   endtask : ran_out

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [7:0] swp(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction : swp

   function automatic logic [7:0] mrd(input logic [7:0] x);
      if (x >= 8'h85 && x <= 8'h87)
         return dirm[x - 8'h85];
      return mem[x[6:0]];
   endfunction : mrd

   task automatic mwr(input logic [7:0] x, v);
      if (x >= 8'h85 && x <= 8'h87)
         dirm[x - 8'h85] = v;
      else
         mem[x[6:0]] = v;
   endtask : mwr

   // ---------------------------------------------------------------
   // Port drivers
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] x, d);
      int n;
      reg_addr = x;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      for (n = 0; n < 20 && reg_wr_done !== 1'b1; n++)
         tick;
      reg_wr_en = 1'b0;
      if (n == 20)
         ran_out;
      mwr(x, d);
      // A gap keeps the previous done pulse from ending the next wait
      tick;
   endtask : wr

   task automatic rd(input logic [7:0] x, output logic [7:0] d);
      int n;
      reg_addr = x;
      reg_rd_en = 1'b1;
      tick;
      reg_rd_en = 1'b0;
      for (n = 0; n < 20 && reg_rd_valid !== 1'b1; n++)
         tick;
      if (n == 20)
         ran_out;
      d = reg_rd_data;
   endtask : rd

   task automatic wload(input logic [7:0] d);
      w_load_en = 1'b1;
      w_load_data = d;
      tick;
      w_load_en = 1'b0;
      tick;
      wm = d;
   endtask : wload

   task automatic exec(input logic [13:0] i, input logic b, ok);
      instr = i;
      bank_sel = b;
      instr_valid = 1'b1;
      tick;
      instr_valid = 1'b0;
      cmp_bit(retire, 1'b0, "retire early");
      tick;
      cmp_bit(retire, ok, "retire");
      tick;
      cmp_bit(retire, 1'b0, "retire width");
   endtask : exec

   task automatic swap_case(input logic [7:0] x, input logic d);
      logic [7:0] v;
      v = mrd(x);
      exec({SWAP_OPCODE, d, x[6:0]}, x[7], 1'b1);
      if (d)
         mwr(x, swp(v));
      else
         wm = swp(v);
      cmp(w_reg, wm, "w after swap");
      rd(x, got);
      cmp(got, mrd(x), "reg after swap");
   endtask : swap_case

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {sys_rst, instr_valid, bank_sel, w_load_en} = 4'h8;
      {reg_wr_en, reg_rd_en} = 2'h0;
      instr = 14'h0000;
      reg_addr = 8'h00;
      {w_load_data, reg_wr_data} = 16'h0000;
      num_errors = 0;
      checked = 0;
      seed = 34;
      dirm = '{8'hFF, 8'hFF, 8'hFF};
      wm = 8'h00;
      repeat (3) tick;
      sys_rst = 1'b0;
      tick;
      cmp(w_reg, 8'h00, "w reset");
      cmp(dir_a & dir_b & dir_c, 8'hFF, "dir reset");
      wr(8'h20, 8'hA5);
      swap_case(8'h20, 1'b0);
      wr(8'h86, 8'h3C);
      cmp(dir_b, 8'h3C, "dir by address");
      rd(8'h86, got);
      cmp(got, 8'h3C, "dir read");
      swap_case(8'h86, 1'b1);
      cmp(dir_b, 8'hC3, "dir swapped");
      for (int f = 4; f < 8; f++)
      begin
         wload(8'(rnd()));
         exec({DIRLOAD_OPCODE, 3'(f)}, 1'b0, f >= 5);
         if (f >= 5)
            dirm[f - 5] = wm;
         cmp(dir_a, dirm[0], "dir a");
         cmp(dir_b, dirm[1], "dir b");
         cmp(dir_c, dirm[2], "dir c");
      end
      // Two in-place swaps back to back restore the value
      wr(8'h31, 8'h96);
      instr = {SWAP_OPCODE, 1'b1, 7'h31};
      bank_sel = 1'b0;
      instr_valid = 1'b1;
      tick;
      tick;
      instr_valid = 1'b0;
      cmp_bit(retire, 1'b1, "first retire");
      tick;
      cmp_bit(retire, 1'b1, "second retire");
      rd(8'h31, got);
      cmp(got, 8'h96, "double swap");
      // Corner: a write is refused while an in-place swap executes, and
      // a W load on the execute edge loses to a swap into W
      wr(8'h40, 8'h12);
      instr = {SWAP_OPCODE, 1'b1, 7'h40};
      instr_valid = 1'b1;
      tick;
      instr = {SWAP_OPCODE, 1'b0, 7'h40};
      reg_addr = 8'h41;
      reg_wr_data = 8'h77;
      reg_wr_en = 1'b1;
      tick;
      instr_valid = 1'b0;
      w_load_en = 1'b1;
      w_load_data = 8'hEE;
      cmp_bit(reg_wr_done, 1'b0, "write refused");
      tick;
      w_load_en = 1'b0;
      reg_wr_en = 1'b0;
      mwr(8'h40, swp(mrd(8'h40)));
      wm = swp(mrd(8'h40));
      mwr(8'h41, 8'h77);
      cmp(w_reg, wm, "w load loses");
      cmp_bit(reg_wr_done, 1'b1, "write retried");
      tick;
      rd(8'h40, got);
      cmp(got, mrd(8'h40), "swap beside write");
      rd(8'h41, got);
      cmp(got, mrd(8'h41), "write after refusal");
      repeat (24)
      begin
         a = 8'(rnd());
         wr(a, 8'(rnd()));
         wload(8'(rnd()));
         swap_case(a, 1'(rnd()));
      end
      give_verdict;
   end

endmodule : tb_top
